// [hdl/dsrb_bank.sv]
// drive status readback bank with apb slave and interrupt logic
`timescale 1ns/1ns

// Operation
// (R1) fault bit set while fault active
// (R2) fault bits 0-7 memory through secondary feedback
// (R3) fault bits 8-15 primary feedback through overspeed
// (R4) fault bits 16-23 overcurrent through module temperature
// (R5) fault bits 24-30 ground through hardware failure
// (R6) fault bit 31 reserved, reads zero
// (R7) warning bit set while warning active
// (R8) warning bits 0-3 temperature warnings
// (R9) warning bits 4-5 overtravel plus, minus
// (R10) analog count clamped to -8192..8191
// (R11) analog scale 8192 counts per 10 volts
// (R12) input n maps to bit n-1
// (R13) input word bits 8-31 undefined
// (R14) input bit one when on
// (R15) unassigned inputs read zero
// (R16) status words read-only, writes ignored
module dsrb_bank import dsrb_pkg::*; (
    input wire logic clock,
    input wire logic rstn,
    input wire dsrb_drive_s drive,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    // ------------------------------------------------------------------
    // status words
    // ------------------------------------------------------------------
    logic [31:0] fault_word;
    logic [31:0] warn_word;
    logic [31:0] analog_word;
    logic [31:0] input_word;
    logic [7:0] assign_mask;
    logic [3:0] irq_stat;
    logic [3:0] irq_en;
    logic signed [15:0] next_analog;
    dsrb_apb_req_s req;
    logic setup;
    logic wr_take;
    logic [3:0] irq_evt;
    logic [3:0] irq_clr;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                   pwdata: pwdata};
    // answer in the access cycle right after setup: one wait-free access
    assign setup = req.psel && !req.penable;
    assign wr_take = req.psel && req.penable && pready && req.pwrite;

    // clamp the converter count; the source already scales 8192 per 10 V
    always_comb begin
        if (drive.analog_raw > DSRB_ANALOG_MAX) begin
            next_analog = DSRB_ANALOG_MAX; // see (R10)
        end else if (drive.analog_raw < DSRB_ANALOG_MIN) begin
            next_analog = DSRB_ANALOG_MIN; // see (R10)
        end else begin
            next_analog = drive.analog_raw; // see (R11)
        end
    end

    // fault word tracks live faults; msb reserved, held at zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fault_word <= DSRB_RST_WORD;
        end else begin
            fault_word <= {1'b0, drive.faults}; // see (R1) see (R2) see (R3) see (R4) see (R5) see (R6)
        end
    end

    // warning word tracks live warnings; upper bits zero
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            warn_word <= DSRB_RST_WORD;
        end else begin
            warn_word <= {26'h0, drive.warnings}; // see (R7) see (R8) see (R9)
        end
    end

    // analog word sign-extended to the bus width
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            analog_word <= DSRB_RST_WORD;
        end else begin
            analog_word <= {{16{next_analog[15]}}, next_analog}; // see (R10)
        end
    end

    // inputs gated by the host assignment; undefined bits read zero here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            input_word <= DSRB_RST_WORD;
        end else begin
            input_word <= {24'h0, drive.inputs & assign_mask}; // see (R12) see (R14) see (R15) see (R13)
        end
    end

    // ------------------------------------------------------------------
    // writable control: input assignment and interrupt enable
    // ------------------------------------------------------------------
    // status word offsets have no write path, so writes to them vanish
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            assign_mask <= DSRB_RST_ASSIGN;
            irq_en <= DSRB_RST_IRQ;
        end else if (wr_take) begin // see (R16)
            if (req.paddr == DSRB_OFF_ASSIGN) begin
                assign_mask <= req.pwdata[7:0];
            end
            if (req.paddr == DSRB_OFF_IRQ_EN) begin
                irq_en <= req.pwdata[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky on any change of the fault, warning or input word
    // ------------------------------------------------------------------
    assign irq_evt[DSRB_IRQ_FAULT_POS] = ({1'b0, drive.faults} != fault_word);
    assign irq_evt[DSRB_IRQ_WARN_POS] = ({26'h0, drive.warnings} != warn_word);
    assign irq_evt[DSRB_IRQ_INPUT_POS] =
        ({24'h0, drive.inputs & assign_mask} != input_word);
    assign irq_evt[DSRB_IRQ_CLEAR_POS] = 1'b0;
    assign irq_clr = (wr_take && req.paddr == DSRB_OFF_IRQ_CLR) ? req.pwdata[3:0] : 4'h0;

    // set beats clear so a change during the clear write is kept
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_stat <= DSRB_RST_IRQ;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
        end
    end

    // level interrupt from a flop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irq_stat & ~irq_clr) | irq_evt) & irq_en);
        end
    end

    // ------------------------------------------------------------------
    // apb answer: read data latched at setup, ready in the access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prdata <= DSRB_RST_WORD;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= DSRB_RST_WORD;
            unique case (req.paddr)
                DSRB_OFF_FAULT: prdata <= fault_word;
                DSRB_OFF_WARN: prdata <= warn_word;
                DSRB_OFF_ANALOG: prdata <= analog_word;
                DSRB_OFF_INPUTS: prdata <= input_word;
                DSRB_OFF_ASSIGN: prdata <= {24'h0, assign_mask};
                DSRB_OFF_IRQ_STAT: prdata <= {28'h0, irq_stat};
                DSRB_OFF_IRQ_EN: prdata <= {28'h0, irq_en};
                DSRB_OFF_IRQ_CLR: prdata <= DSRB_RST_WORD;
                default: pslverr <= 1'b1;
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_fault_track;
        @(posedge clock) disable iff (!rstn)
        fault_word[30:0] == $past(drive.faults);
    endproperty
    a_fault_track: assert property (p_fault_track) else $error("fault word lags"); // see (R1)

    property p_fault_rsvd;
        @(posedge clock) disable iff (!rstn) fault_word[DSRB_FAULT_RSVD_POS] == 1'b0;
    endproperty
    a_fault_rsvd: assert property (p_fault_rsvd) else $error("reserved fault bit set"); // see (R6)

    property p_warn_track;
        @(posedge clock) disable iff (!rstn)
        warn_word == {26'h0, $past(drive.warnings)};
    endproperty
    a_warn_track: assert property (p_warn_track) else $error("warning word wrong"); // see (R7)

    property p_analog_range;
        @(posedge clock) disable iff (!rstn)
        $signed(analog_word) <= 32'sd8191 && $signed(analog_word) >= -32'sd8192;
    endproperty
    a_analog_range: assert property (p_analog_range) else $error("analog out of range"); // see (R10)

    property p_analog_pass;
        @(posedge clock) disable iff (!rstn)
        ($signed(drive.analog_raw) == 16'sd4096) |=> analog_word == 32'h0000_1000;
    endproperty
    a_analog_pass: assert property (p_analog_pass) else $error("analog scale wrong"); // see (R11)

    property p_input_gate;
        @(posedge clock) disable iff (!rstn)
        (input_word[7:0] & ~$past(assign_mask)) == 8'h00 && input_word[31:8] == 24'h0;
    endproperty
    a_input_gate: assert property (p_input_gate) else $error("unassigned input read one"); // see (R15)

    property p_input_on;
        @(posedge clock) disable iff (!rstn)
        input_word[7:0] == ($past(drive.inputs) & $past(assign_mask));
    endproperty
    a_input_on: assert property (p_input_on) else $error("input bit mismatch"); // see (R12)

    property p_ro_write;
        @(posedge clock) disable iff (!rstn)
        (wr_take && req.paddr == DSRB_OFF_FAULT) |=> fault_word[30:0] == $past(drive.faults);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write reached fault word"); // see (R16)

    property p_ready_one;
        @(posedge clock) disable iff (!rstn) setup |=> pready ##1 !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready timing wrong");

    // ------------------------------------------------------------------
    // assertions: bit layout of the status words
    // ------------------------------------------------------------------
    // one property per fault group, so a failure names the group at once
    property p_flt_a;
        @(posedge clock) disable iff (!rstn)
        fault_word[7:0] == $past(drive.faults[7:0]);
    endproperty
    a_flt_a: assert property (p_flt_a) else $error("fault bits 0-7 wrong"); // see (R2)

    property p_flt_b;
        @(posedge clock) disable iff (!rstn)
        fault_word[15:8] == $past(drive.faults[15:8]);
    endproperty
    a_flt_b: assert property (p_flt_b) else $error("fault bits 8-15 wrong"); // see (R3)

    property p_flt_c;
        @(posedge clock) disable iff (!rstn)
        fault_word[23:16] == $past(drive.faults[23:16]);
    endproperty
    a_flt_c: assert property (p_flt_c) else $error("fault bits 16-23 wrong"); // see (R4)

    property p_flt_d;
        @(posedge clock) disable iff (!rstn)
        fault_word[30:24] == $past(drive.faults[30:24]);
    endproperty
    a_flt_d: assert property (p_flt_d) else $error("fault bits 24-30 wrong"); // see (R5)

    // warnings: temperature group, overtravel pair, idle upper bits
    property p_warn_temp;
        @(posedge clock) disable iff (!rstn)
        warn_word[3:0] == $past(drive.warnings[3:0]);
    endproperty
    a_warn_temp: assert property (p_warn_temp) else $error("temperature warning wrong"); // see (R8)

    property p_warn_trav;
        @(posedge clock) disable iff (!rstn)
        warn_word[5:4] == $past(drive.warnings[5:4]);
    endproperty
    a_warn_trav: assert property (p_warn_trav) else $error("overtravel warning wrong"); // see (R9)

    property p_warn_upper;
        @(posedge clock) disable iff (!rstn) warn_word[31:6] == 26'h0;
    endproperty
    a_warn_upper: assert property (p_warn_upper) else $error("unused warning bit set"); // see (R7)

    // clamp ends are checked by value; a wrapped count would land far outside
    property p_ana_sign;
        @(posedge clock) disable iff (!rstn)
        analog_word[31:16] == {16{analog_word[15]}};
    endproperty
    a_ana_sign: assert property (p_ana_sign) else $error("analog sign extension wrong"); // see (R10)

    property p_ana_hi;
        @(posedge clock) disable iff (!rstn)
        (drive.analog_raw > DSRB_ANALOG_MAX) |=> analog_word == 32'(DSRB_ANALOG_MAX);
    endproperty
    a_ana_hi: assert property (p_ana_hi) else $error("analog upper clamp wrong"); // see (R10)

    property p_ana_lo;
        @(posedge clock) disable iff (!rstn)
        (drive.analog_raw < DSRB_ANALOG_MIN) |=> analog_word == 32'(DSRB_ANALOG_MIN);
    endproperty
    a_ana_lo: assert property (p_ana_lo) else $error("analog lower clamp wrong"); // see (R10)

    property p_ana_zero;
        @(posedge clock) disable iff (!rstn)
        (drive.analog_raw == 16'sd0) |=> analog_word == 32'h0000_0000;
    endproperty
    a_ana_zero: assert property (p_ana_zero) else $error("zero volts not zero counts"); // see (R11)

    // an input that is off must never read as on, whatever the mask says
    property p_in_off;
        @(posedge clock) disable iff (!rstn)
        (input_word[7:0] & ~$past(drive.inputs)) == 8'h00;
    endproperty
    a_in_off: assert property (p_in_off) else $error("off input read as on"); // see (R14)

    // ------------------------------------------------------------------
    // assertions: write protection and bus answers
    // ------------------------------------------------------------------
    // a write to a status offset must leave the word tracking the drive
    property p_ro_warn;
        @(posedge clock) disable iff (!rstn)
        (wr_take && req.paddr == DSRB_OFF_WARN) |=> warn_word == {26'h0, $past(drive.warnings)};
    endproperty
    a_ro_warn: assert property (p_ro_warn) else $error("write reached warning word"); // see (R16)

    property p_ro_ana;
        @(posedge clock) disable iff (!rstn)
        (wr_take && req.paddr == DSRB_OFF_ANALOG) |=> analog_word[15:0] == $past(next_analog);
    endproperty
    a_ro_ana: assert property (p_ro_ana) else $error("write reached analog word"); // see (R16)

    property p_ro_in;
        @(posedge clock) disable iff (!rstn)
        (wr_take && req.paddr == DSRB_OFF_INPUTS) |=>
            input_word[7:0] == ($past(drive.inputs) & $past(assign_mask));
    endproperty
    a_ro_in: assert property (p_ro_in) else $error("write reached input word"); // see (R16)

    property p_mask_wr;
        @(posedge clock) disable iff (!rstn)
        (wr_take && req.paddr == DSRB_OFF_ASSIGN) |=> assign_mask == $past(pwdata[7:0]);
    endproperty
    a_mask_wr: assert property (p_mask_wr) else $error("assignment write lost"); // see (R15)

    // unmapped offsets answer with an error and an all-zero word
    property p_unmapped;
        @(posedge clock) disable iff (!rstn)
        (setup && (req.paddr > DSRB_OFF_IRQ_CLR || req.paddr[1:0] != 2'b00)) |=>
            pslverr && prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped offset not refused");

    property p_clr_read;
        @(posedge clock) disable iff (!rstn)
        (setup && !req.pwrite && req.paddr == DSRB_OFF_IRQ_CLR) |=> prdata == 32'h0000_0000;
    endproperty
    a_clr_read: assert property (p_clr_read) else $error("clear register read not zero");

    // ------------------------------------------------------------------
    // assertions: interrupt status and line
    // ------------------------------------------------------------------
    // the line comes from a flop fed with the next status, so it moves with the status on the same edge
    property p_irq_level;
        @(posedge clock) disable iff (!rstn)
        irq == |(irq_stat & $past(irq_en));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt line wrong");

    property p_irq_sticky;
        @(posedge clock) disable iff (!rstn)
        (($past(irq_stat) & ~$past(irq_clr)) & ~irq_stat) == 4'h0;
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("status bit dropped");

    property p_irq_set;
        @(posedge clock) disable iff (!rstn)
        (irq_evt != 4'h0) |=> (irq_stat & $past(irq_evt)) == $past(irq_evt);
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("event lost to clear");

    property p_irq_spare;
        @(posedge clock) disable iff (!rstn) irq_stat[DSRB_IRQ_CLEAR_POS] == 1'b0;
    endproperty
    a_irq_spare: assert property (p_irq_spare) else $error("spare status bit set");

    c_fault_read: cover property (@(posedge clock) disable iff (!rstn)
        setup && !req.pwrite && req.paddr == DSRB_OFF_FAULT ##1 prdata != 32'h0);
    c_irq: cover property (@(posedge clock) disable iff (!rstn) $rose(irq));
    c_clamp: cover property (@(posedge clock) disable iff (!rstn)
        drive.analog_raw > DSRB_ANALOG_MAX);
    c_bad_addr: cover property (@(posedge clock) disable iff (!rstn) pslverr);

endmodule : dsrb_bank

// [hdl/dsrb_pkg.sv]
// package for the drive status readback bank: offsets, field layouts, types
package dsrb_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DSRB_OFF_FAULT = 8'h00;
    localparam logic [7:0] DSRB_OFF_WARN = 8'h04;
    localparam logic [7:0] DSRB_OFF_ANALOG = 8'h08;
    localparam logic [7:0] DSRB_OFF_INPUTS = 8'h0c;
    localparam logic [7:0] DSRB_OFF_ASSIGN = 8'h10;
    localparam logic [7:0] DSRB_OFF_IRQ_STAT = 8'h14;
    localparam logic [7:0] DSRB_OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] DSRB_OFF_IRQ_CLR = 8'h1c;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam int DSRB_FAULT_BITS = 31;
    localparam int DSRB_FAULT_RSVD_POS = 31;
    localparam int DSRB_WARN_BITS = 6;
    localparam int DSRB_ANALOG_BITS = 14;
    localparam int DSRB_INPUT_BITS = 8;
    localparam int DSRB_IRQ_BITS = 4;
    localparam int DSRB_IRQ_FAULT_POS = 0;
    localparam int DSRB_IRQ_WARN_POS = 1;
    localparam int DSRB_IRQ_INPUT_POS = 2;
    localparam int DSRB_IRQ_CLEAR_POS = 3;
    localparam logic signed [15:0] DSRB_ANALOG_MAX = 16'sh1fff;
    localparam logic signed [15:0] DSRB_ANALOG_MIN = -16'sh2000;
    localparam logic [31:0] DSRB_RST_WORD = 32'h0000_0000;
    localparam logic [7:0] DSRB_RST_ASSIGN = 8'h00;
    localparam logic [3:0] DSRB_RST_IRQ = 4'h0;

    // raw condition of the drive as seen by the bank
    typedef struct packed {
        logic [30:0] faults;
        logic [5:0] warnings;
        logic signed [15:0] analog_raw;
        logic [7:0] inputs;
    } dsrb_drive_s;

    // apb request group
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dsrb_apb_req_s;

endpackage : dsrb_pkg

// [tb/dsrb_drive_model.sv]
// behavioural model of the servo drive that feeds live status levels to the bank
`timescale 1ns/1ns
module dsrb_drive_model import dsrb_pkg::*; (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [30:0] fault_set,
    input wire logic [5:0] warn_set,
    input wire logic signed [15:0] millivolts,
    input wire logic [7:0] input_on,
    output dsrb_drive_s drive
);
    // ------------------------------------------------------------------
    // drive condition
    // ------------------------------------------------------------------
    // levels follow the request one edge later; the raw count is not clamped,
    // so overrange voltages reach the bank as they would from a real converter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drive <= '0;
        end else begin
            drive.faults <= fault_set;
            drive.warnings <= warn_set;
            drive.analog_raw <= 16'(int'(millivolts) * 8192 / 10000);
            drive.inputs <= input_on;
        end
    end
endmodule : dsrb_drive_model

// [tb/dsrb_bank_tb_top.sv]
// self-checking testbench for the drive status readback bank
`timescale 1ns/1ns
module dsrb_bank_tb_top import dsrb_pkg::*;;
    logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0, input_on = 0, mask = 0;
    logic [31:0] pwdata = 0, prdata, rdata;
    logic pready, pslverr, irq, rerr;
    logic [30:0] fault_set = 0;
    logic [5:0] warn_set = 0;
    logic signed [15:0] millivolts = 0;
    logic signed [15:0] mv_tab [6] = '{0, 10000, -10000, 5000, 12000, -12000};
    dsrb_drive_s drive;
    integer seed = 39855, fails = 0, check_count = 0, i, k;

    dsrb_drive_model model (.clock(clock), .rstn(rstn), .fault_set(fault_set),
        .warn_set(warn_set), .millivolts(millivolts), .input_on(input_on), .drive(drive));
    dsrb_bank dut (.clock(clock), .rstn(rstn), .drive(drive), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    // 100 ns period
    initial begin
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task wrap_up;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; ready, read data and error are taken at the edge ending the access
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (k = 0; k < 16 && !got; k++) begin
            @(posedge clock);
            if (pready === 1'b1) begin
                got = 1;
                rdata = prdata;
                rerr = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!got) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: no pready", $time);
            wrap_up();
        end
    endtask : apb

    // settle over the model and bank lags, then look mid-cycle
    task settle;
        repeat (5) @(posedge clock);
        @(negedge clock);
    endtask : settle

    function automatic logic [31:0] exp_analog(input int mv);
        int c;
        c = mv * 8192 / 10000;
        if (c > 8191) c = 8191;
        if (c < -8192) c = -8192;
        return c[31:0];
    endfunction : exp_analog

    // ------------------------------------------------------------------
    // main sequence: one-hot then random status, then interrupts
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        for (i = 0; i < 48; i++) begin
            fault_set <= (i < 31) ? 31'(1) << i : 31'($random(seed));
            warn_set <= (i < 6) ? 6'(1) << i : 6'($random(seed));
            millivolts <= (i < 6) ? mv_tab[i] : 16'($random(seed) % 12000);
            input_on <= 8'($random(seed));
            settle();
            apb(1'b1, 8'((i % 4) * 4), 32'hffff_ffff);
            apb(1'b0, DSRB_OFF_FAULT, 0);
            chk(rdata, {1'b0, fault_set});
            apb(1'b0, DSRB_OFF_WARN, 0);
            chk(rdata, {26'h0, warn_set});
            apb(1'b0, DSRB_OFF_ANALOG, 0);
            chk(rdata, exp_analog(millivolts));
            apb(1'b0, DSRB_OFF_INPUTS, 0);
            chk(rdata, {24'h0, input_on & mask});
            chk({31'h0, irq}, 32'h0);
            mask = 8'($random(seed));
            apb(1'b1, DSRB_OFF_ASSIGN, {24'h0, mask});
        end
        apb(1'b0, 8'h20, 0);
        chk({rerr, rdata[30:0]}, 32'h8000_0000);
        apb(1'b1, DSRB_OFF_IRQ_CLR, 32'hf);
        apb(1'b1, DSRB_OFF_IRQ_EN, 32'h1);
        apb(1'b0, DSRB_OFF_IRQ_EN, 0);
        chk(rdata, 32'h1);
        @(posedge clock);
        fault_set <= ~fault_set;
        settle();
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, DSRB_OFF_IRQ_STAT, 32'h0);
        apb(1'b0, DSRB_OFF_IRQ_STAT, 0);
        chk(rdata, 32'h1);
        apb(1'b1, DSRB_OFF_IRQ_CLR, 32'h1);
        @(posedge clock);
        warn_set <= ~warn_set;
        settle();
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, DSRB_OFF_IRQ_STAT, 0);
        chk(rdata, 32'h2);
        apb(1'b0, DSRB_OFF_IRQ_CLR, 0);
        chk(rdata, 32'h0);
        apb(1'b0, DSRB_OFF_ASSIGN, 0);
        chk(rdata, {24'h0, mask});
        // mid-run reset: the input gate and the enables must start over closed
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        apb(1'b0, DSRB_OFF_INPUTS, 0);
        chk(rdata, 32'h0);
        apb(1'b0, DSRB_OFF_IRQ_EN, 0);
        chk(rdata, 32'h0);
        wrap_up();
    end
endmodule : dsrb_bank_tb_top
